// ---- verilog/pcum_consts.vh ----
/*
 constants for the upper port pin multiplexer: register offsets, reset values, bit positions.
 assumes it is included by bare name from design files.
*/
`ifndef PCUM_CONSTS_VH
`define PCUM_CONSTS_VH

// ----------------------------------------
// register offsets (chosen locally)
// ----------------------------------------
`define PCUM_ADDR_W 4
`define PCUM_OFF_PIN 4'h0
`define PCUM_OFF_LAT 4'h1
`define PCUM_OFF_DIR 4'h2
`define PCUM_OFF_CFG 4'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define PCUM_DIR_RST 8'hff
`define PCUM_LAT_RST 8'h00
`define PCUM_CFG_RST 8'h01

// ----------------------------------------
// configuration register fields
// ----------------------------------------
`define PCUM_CFG_CMP2_SEL 0

// ----------------------------------------
// pin positions
// ----------------------------------------
`define PCUM_PIN_SCLK 3
`define PCUM_PIN_SDAT 4
`define PCUM_PIN_SDO 5
`define PCUM_PIN_TX 6
`define PCUM_PIN_RX 7
`define PCUM_PIN_CMP2 1

`endif

// ---- verilog/pcum_sync.v ----
/*
 two-stage synchroniser for an 8-bit pin level bus.
 assumes pin levels are asynchronous and only the second stage is read.
*/
`timescale 1ns/10ps

module pcum_sync (
  input wire i_ref_clk,
  input wire i_srst,
  input wire [7:0] i_async,
  output wire [7:0] o_sync
);
  reg [7:0] stage1_reg;
  reg [7:0] stage2_reg;

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      stage1_reg <= 8'h00;
      stage2_reg <= 8'h00;
    end else begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
    end
  end

  assign o_sync = stage2_reg;
endmodule // pcum_sync

// ---- verilog/pcum_port_mux.v ----
/*
 upper port pin multiplexer: pin, latch and direction registers, peripheral overrides on
 pins 3 to 7, and routing of compare channel two to its default or alternate pin.
 assumes peripheral controls are synchronous to i_ref_clk and that pad Schmitt buffers
 sit outside this block; pin levels arrive through o_pin_oe-resolved pads.
*/
// The implementer's own choices: the register addresses and strobed register access.
//
// How it works
// [R1] direction one tristates, zero drives latch
// [R2] latch reads return latch, not pins
// [R3] reset makes every pin an input
// [R4] serial master clock drives pin 3 output
// [R5] slave clock in from pin 3
// [R6] two-wire clock/data override pins 3, 4
// [R7] serial data in from pin 4 input
// [R8] serial data out drives pin 5
// [R9] async transmitter drives pin 6
// [R10] software clears pin 6 direction first
// [R11] sync clock on pin 6 out or in
// [R12] async receive data from pin 7
// [R13] sync data out drives pin 7
// [R14] software sets pin 7 direction to receive
// [R15] peripheral may override the direction bit
// [R16] compare two routed by select bit
// [R17] latch eight bits; pin register bit per pin
// [R18] inputs Schmitt buffered, outputs digital levels
// [R19] latch writes held during override
// [R20] pin reads return synchronized pin levels
`timescale 1ns/10ps
`include "pcum_consts.vh"

module pcum_port_mux (
  input wire i_ref_clk,
  input wire i_srst,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire [7:0] i_pin,
  output reg [7:0] o_pin_out,
  output reg [7:0] o_pin_oe,
  input wire i_ssm_en,
  input wire i_ssm_master,
  input wire i_ssm_twowire,
  input wire i_ssm_smbus,
  input wire i_ssm_sck_out,
  input wire i_ssm_sdo,
  input wire i_ssm_scl_drv_low,
  input wire i_ssm_sda_drv_low,
  output reg o_ssm_sck_in,
  output reg o_ssm_sdi,
  output reg o_ssm_smbus_levels,
  input wire i_esm_en,
  input wire i_esm_sync,
  input wire i_esm_clk_master,
  input wire i_esm_tx,
  input wire i_esm_ck_out,
  input wire i_esm_dt_out,
  input wire i_esm_dt_drive,
  output reg o_esm_rx,
  output reg o_esm_ck_in,
  input wire i_cmp2_out,
  input wire i_cmp2_drive,
  output reg o_cmp2_alt_out,
  output reg o_cmp2_alt_oe,
  output reg o_cmp2_sel
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] lat_reg;
  reg [7:0] dir_reg;
  reg [7:0] cfg_reg;
  wire [7:0] pin_sync;
  reg [7:0] out_next;
  reg [7:0] oe_next;
  reg [7:0] rdata_next;

  // pins float asynchronously, so they are synchronized before any read
  pcum_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_async(i_pin),
    .o_sync(pin_sync)
  );

  function hit;
    input [3:0] addr;
    input [3:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  wire wr_lat;
  wire wr_dir;
  wire wr_cfg;

  // a write to either the pin or latch register lands in the latch
  assign wr_lat = i_wr & (hit(i_addr, `PCUM_OFF_PIN) | hit(i_addr, `PCUM_OFF_LAT));
  assign wr_dir = i_wr & hit(i_addr, `PCUM_OFF_DIR);
  assign wr_cfg = i_wr & hit(i_addr, `PCUM_OFF_CFG);

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      lat_reg <= `PCUM_LAT_RST;
      dir_reg <= `PCUM_DIR_RST; // see [R3]
      cfg_reg <= `PCUM_CFG_RST;
    end else begin
      if (wr_lat) begin
        lat_reg <= i_wdata; // see [R17] see [R19]
      end
      if (wr_dir) begin
        dir_reg <= i_wdata;
      end
      if (wr_cfg) begin
        cfg_reg <= {7'h00, i_wdata[`PCUM_CFG_CMP2_SEL]};
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always @* begin
    rdata_next = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `PCUM_OFF_PIN: rdata_next = pin_sync; // see [R20] see [R17]
        `PCUM_OFF_LAT: rdata_next = lat_reg; // see [R2]
        `PCUM_OFF_DIR: rdata_next = dir_reg;
        `PCUM_OFF_CFG: rdata_next = cfg_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // pin ownership decode
  // ----------------------------------------
  // a peripheral output claims its pin only while the direction bit reads zero
  function claim;
    input enable;
    input dir_bit;
    begin
      claim = enable & ~dir_bit;
    end
  endfunction

  // a peripheral input hears the pin only while the pin is an input, and rests at
  // its idle level otherwise; for three cycles after the direction bit turns to one it still hears the block's own drive
  function gate_in;
    input dir_bit;
    input level;
    input idle;
    begin
      gate_in = dir_bit ? level : idle;
    end
  endfunction

  wire ssm_twowire_on;
  wire ssm_spi_on;
  wire esm_async_on;
  wire esm_sync_on;
  wire cmp2_claim;
  wire scl_claim;
  wire sda_claim;
  wire sck_claim;
  wire sdo_claim;
  wire ck_claim;
  wire dt_claim;
  reg [2:0] low_out;
  reg [2:0] low_oe;
  reg pin3_out;
  reg pin3_oe;
  reg pin4_out;
  reg pin4_oe;
  reg pin5_out;
  reg pin5_oe;
  reg pin6_out;
  reg pin6_oe;
  reg pin7_out;
  reg pin7_oe;

  assign ssm_twowire_on = i_ssm_en & i_ssm_twowire;
  assign ssm_spi_on = i_ssm_en & ~i_ssm_twowire;
  assign esm_async_on = i_esm_en & ~i_esm_sync;
  assign esm_sync_on = i_esm_en & i_esm_sync;
  // compare two owns pin 1 only when routed there
  assign cmp2_claim = claim(cfg_reg[`PCUM_CFG_CMP2_SEL] & i_cmp2_drive,
    dir_reg[`PCUM_PIN_CMP2]); // see [R16]
  assign scl_claim = claim(ssm_twowire_on, dir_reg[`PCUM_PIN_SCLK]); // see [R6]
  assign sda_claim = claim(ssm_twowire_on, dir_reg[`PCUM_PIN_SDAT]); // see [R6]
  assign sck_claim = claim(ssm_spi_on & i_ssm_master, dir_reg[`PCUM_PIN_SCLK]); // see [R4]
  assign sdo_claim = claim(ssm_spi_on, dir_reg[`PCUM_PIN_SDO]); // see [R8]
  assign ck_claim = claim(esm_sync_on & i_esm_clk_master, dir_reg[`PCUM_PIN_TX]); // see [R11]
  assign dt_claim = claim(esm_sync_on, dir_reg[`PCUM_PIN_RX]); // see [R13]

  // ----------------------------------------
  // pins 0 to 2: port data, compare two on pin 1
  // ----------------------------------------
  always @* begin
    low_out = lat_reg[2:0];
    low_oe = ~dir_reg[2:0]; // see [R1]
    if (cmp2_claim) begin
      low_out[`PCUM_PIN_CMP2] = i_cmp2_out; // see [R16]
    end
  end

  // ----------------------------------------
  // pin 3: port data, spi clock or two-wire clock
  // ----------------------------------------
  always @* begin
    pin3_out = lat_reg[`PCUM_PIN_SCLK];
    pin3_oe = ~dir_reg[`PCUM_PIN_SCLK]; // see [R1]
    if (scl_claim) begin
      // open-drain: drive low only, released high is the pull-up's job
      pin3_out = 1'b0; // see [R6]
      pin3_oe = i_ssm_scl_drv_low;
    end else if (sck_claim) begin
      pin3_out = i_ssm_sck_out; // see [R4]
    end
  end

  // ----------------------------------------
  // pin 4: port data or two-wire data
  // ----------------------------------------
  always @* begin
    pin4_out = lat_reg[`PCUM_PIN_SDAT];
    pin4_oe = ~dir_reg[`PCUM_PIN_SDAT]; // see [R1]
    if (sda_claim) begin
      pin4_out = 1'b0; // see [R6]
      pin4_oe = i_ssm_sda_drv_low;
    end
  end

  // ----------------------------------------
  // pin 5: port data or spi data out
  // ----------------------------------------
  always @* begin
    pin5_out = lat_reg[`PCUM_PIN_SDO];
    pin5_oe = ~dir_reg[`PCUM_PIN_SDO]; // see [R1]
    if (sdo_claim) begin
      pin5_out = i_ssm_sdo; // see [R8]
    end
  end

  // ----------------------------------------
  // pin 6: port data, async transmit or sync clock
  // ----------------------------------------
  always @* begin
    pin6_out = lat_reg[`PCUM_PIN_TX];
    pin6_oe = ~dir_reg[`PCUM_PIN_TX]; // see [R1]
    if (esm_async_on) begin
      // the value is overridden, the enable is not: software must clear the direction
      pin6_out = i_esm_tx; // see [R9] see [R10]
    end else if (ck_claim) begin
      pin6_out = i_esm_ck_out; // see [R11]
    end
  end

  // ----------------------------------------
  // pin 7: port data or sync data out
  // ----------------------------------------
  always @* begin
    pin7_out = lat_reg[`PCUM_PIN_RX];
    pin7_oe = ~dir_reg[`PCUM_PIN_RX]; // see [R1]
    if (dt_claim) begin
      // the module turns the data pin round itself
      pin7_out = i_esm_dt_out; // see [R13]
      pin7_oe = i_esm_dt_drive; // see [R15] see [R14]
    end
  end

  // ----------------------------------------
  // pin assembly
  // ----------------------------------------
  always @* begin
    out_next = {pin7_out, pin6_out, pin5_out, pin4_out, pin3_out, low_out};
    oe_next = {pin7_oe, pin6_oe, pin5_oe, pin4_oe, pin3_oe, low_oe};
  end

  // ----------------------------------------
  // output and peripheral input flops
  // ----------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
      o_pin_out <= 8'h00;
      o_pin_oe <= 8'h00; // see [R3]
      o_ssm_sck_in <= 1'b0;
      o_ssm_sdi <= 1'b0;
      o_ssm_smbus_levels <= 1'b0;
      o_esm_rx <= 1'b1;
      o_esm_ck_in <= 1'b0;
      o_cmp2_alt_out <= 1'b0;
      o_cmp2_alt_oe <= 1'b0;
      o_cmp2_sel <= 1'b1;
    end else begin
      o_rdata <= rdata_next;
      o_pin_out <= out_next; // see [R18]
      o_pin_oe <= oe_next;
      // inputs pass only while the direction bit makes the pin an input
      o_ssm_sck_in <= gate_in(dir_reg[`PCUM_PIN_SCLK], pin_sync[`PCUM_PIN_SCLK],
        1'b0); // see [R5] see [R6]
      o_ssm_sdi <= gate_in(dir_reg[`PCUM_PIN_SDAT], pin_sync[`PCUM_PIN_SDAT],
        1'b0); // see [R7]
      o_ssm_smbus_levels <= i_ssm_twowire & i_ssm_smbus; // see [R6]
      o_esm_rx <= gate_in(dir_reg[`PCUM_PIN_RX], pin_sync[`PCUM_PIN_RX],
        1'b1); // see [R12]
      o_esm_ck_in <= gate_in(dir_reg[`PCUM_PIN_TX], pin_sync[`PCUM_PIN_TX],
        1'b0); // see [R11]
      o_cmp2_sel <= cfg_reg[`PCUM_CFG_CMP2_SEL];
      o_cmp2_alt_out <= cfg_reg[`PCUM_CFG_CMP2_SEL] ? 1'b0 : i_cmp2_out; // see [R16]
      o_cmp2_alt_oe <= !cfg_reg[`PCUM_CFG_CMP2_SEL] & i_cmp2_drive;
    end
  end

endmodule // pcum_port_mux

// ---- tb/pcum_asserts.sv ----
/* checker for the port mux pin and read outputs.
 assumes it is bound onto pcum_port_mux. */
`timescale 1ns/10ps
module pcum_asserts (
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire [7:0] o_pin_out,
  input wire [7:0] o_pin_oe,
  input wire i_ssm_en,
  input wire i_ssm_twowire,
  input wire i_ssm_sdo,
  input wire i_ssm_scl_drv_low,
  input wire i_esm_en,
  input wire i_esm_sync,
  input wire i_esm_tx,
  input wire o_esm_rx,
  input wire o_ssm_sdi,
  input wire o_cmp2_sel
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  property p_rst; $past(i_srst) |-> o_pin_oe == 8'h00 && o_esm_rx && o_cmp2_sel; endproperty
  a_rst: assert property (p_rst) else $error("pins driven after reset");
  property p_rdz; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside slot");
  property p_tx; $past(i_esm_en && !i_esm_sync) |-> o_pin_out[6] == $past(i_esm_tx); endproperty
  a_tx: assert property (p_tx) else $error("transmit not on pin 6");
  property p_sdo;
    $past(i_ssm_en && !i_ssm_twowire) && o_pin_oe[5] |-> o_pin_out[5] == $past(i_ssm_sdo);
  endproperty
  a_sdo: assert property (p_sdo) else $error("serial out not on pin 5");
  property p_tw; $past(i_ssm_en && i_ssm_twowire && !i_ssm_scl_drv_low) |-> !o_pin_oe[3]; endproperty
  a_tw: assert property (p_tw) else $error("two-wire clock driven high");
  property p_rx; o_pin_oe[7] |-> o_esm_rx; endproperty
  a_rx: assert property (p_rx) else $error("receive fed while pin 7 drives");
  property p_sdi; o_pin_oe[4] |-> !o_ssm_sdi; endproperty
  a_sdi: assert property (p_sdi) else $error("data in fed while pin 4 drives");
  property p_sel; $rose(o_cmp2_sel) |-> $past(i_srst, 2) || $past(i_rd) == 1'b0; endproperty
  a_sel: assert property (p_sel) else $error("select rose during a read");
endmodule // pcum_asserts
bind pcum_port_mux pcum_asserts pcum_asserts_inst (.*);

// ---- tb/pcum_pads.sv ----
/* pad model: resolves each pin from the mux drive and an outside driver.
 assumes pins nobody drives float high through a pull-up. */
`timescale 1ns/10ps
module pcum_pads (
  input wire [7:0] i_out,
  input wire [7:0] i_oe,
  input wire [7:0] i_ext,
  input wire [7:0] i_ext_en,
  output wire [7:0] o_pin
);
  // the outside driver yields wherever the mux drives
  assign o_pin = (i_oe & i_out) | (~i_oe & ((i_ext_en & i_ext) | ~i_ext_en));
endmodule // pcum_pads

// ---- tb/testbench.sv ----
/* self-checking bench for pcum_port_mux.
 assumes the pad model stands on the pin side. */
`timescale 1ns/10ps
module testbench;
  logic clk = 0, srst = 1, wr = 0, rd = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00, ext = 8'h3c, rdata, pout, poe, pin;
  logic [16:0] ctl = 17'h0;
  logic sdi, rx, alt_o, sel, alt_oe, sck_in, ck_in, smb;
  int fail_count = 0, checked = 0;
  // rows: direction, latch, expected enables
  logic [23:0] rows [4] = '{24'hffa500, 24'h00a5ff, 24'hcf3c30, 24'h5ac3a5};
  pcum_port_mux pcum_port_mux_inst (.i_ref_clk(clk), .i_srst(srst), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pin(pin), .o_pin_out(pout),
    .o_pin_oe(poe), .i_ssm_en(ctl[0]), .i_ssm_master(ctl[1]), .i_ssm_twowire(ctl[2]),
    .i_ssm_smbus(ctl[3]), .i_ssm_sck_out(ctl[4]), .i_ssm_sdo(ctl[5]),
    .i_ssm_scl_drv_low(ctl[6]), .i_ssm_sda_drv_low(ctl[7]), .o_ssm_sck_in(sck_in),
    .o_ssm_sdi(sdi), .o_ssm_smbus_levels(smb), .i_esm_en(ctl[8]), .i_esm_sync(ctl[9]),
    .i_esm_clk_master(ctl[10]), .i_esm_tx(ctl[11]), .i_esm_ck_out(ctl[12]),
    .i_esm_dt_out(ctl[13]), .i_esm_dt_drive(ctl[14]), .o_esm_rx(rx), .o_esm_ck_in(ck_in),
    .i_cmp2_out(ctl[15]), .i_cmp2_drive(ctl[16]), .o_cmp2_alt_out(alt_o),
    .o_cmp2_alt_oe(alt_oe), .o_cmp2_sel(sel));
  pcum_pads pcum_pads_inst (.i_out(pout), .i_oe(poe), .i_ext(ext), .i_ext_en(8'hff), .o_pin(pin));
  initial forever #25 clk = ~clk;
  // ----------
  // tasks
  // ----------
  task end_of_test;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task set(input logic [16:0] c);
    @(posedge clk);
    ctl <= c;
  endtask
  task put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task get(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  initial begin
    #100000 fail_count++;
    end_of_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    w(1);
    chk(poe, 8'h00);
    get(4'h2, 8'hff);
    get(4'h1, 8'h00);
    get(4'h3, 8'h01);
    get(4'hf, 8'h00);
    foreach (rows[i]) begin
      put(4'h2, rows[i][23:16]);
      put(4'h0, rows[i][15:8]);
      w(4);
      chk(poe, rows[i][7:0]);
      chk(pout & rows[i][7:0], rows[i][15:8] & rows[i][7:0]);
      get(4'h1, rows[i][15:8]);
      get(4'h0, (rows[i][15:8] & rows[i][7:0]) | (ext & ~rows[i][7:0]));
    end
    put(4'h2, 8'h00);
    put(4'h1, 8'h00);
    set(17'h00921);
    w(2);
    chk(pout & 8'h60, 8'h60);
    put(4'h1, 8'h40);
    set(17'h0);
    w(2);
    chk(pout & 8'h60, 8'h40);
    set(17'h00005);
    w(2);
    chk(poe & 8'h08, 8'h00);
    set(17'h00045);
    w(2);
    chk(poe & 8'h08, 8'h08);
    set(17'h0000d);
    w(2);
    chk({7'h0, smb}, 8'h01);
    set(17'h18000);
    put(4'h3, 8'h00);
    w(2);
    chk({6'h0, sel, alt_o}, 8'h01);
    chk({7'h0, alt_oe}, 8'h01);
    put(4'h2, 8'h90);
    w(4);
    chk({6'h0, rx, sdi}, 8'h01);
    // external clocks on pins 3 and 6 while both are inputs
    ext <= 8'h48;
    put(4'h2, 8'hd8);
    w(4);
    chk({4'h0, sck_in, ck_in, rx, sdi}, 8'h0c);
    put(4'h2, 8'h00);
    put(4'h1, 8'h00);
    set(17'h00013);
    w(2);
    chk(pout & 8'h28, 8'h08);
    set(17'h07700);
    w(2);
    chk(pout & 8'hc0, 8'hc0);
    chk(poe & 8'h80, 8'h80);
    set(17'h03700);
    w(2);
    chk(poe & 8'h80, 8'h00);
    // reset in mid-run must bring every pin back to an input
    set(17'h0);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    w(1);
    chk(poe, 8'h00);
    get(4'h2, 8'hff);
    get(4'h3, 8'h01);
    end_of_test;
  end
endmodule // testbench
